// File: hdl/ppr_pkg.sv
// types shared by the pack protection register bank modules
// assumes nothing of its surroundings
package ppr_pkg;
  typedef logic [7:0] ppr_byte_t;  // one register
  typedef logic [5:0] ppr_flags_t; // operating status flags, bits 5..0
endpackage

// File: hdl/ppr_reg_bank.sv
// register bank of the pack protection front end
// Contract
// R1: writing one acts, reading one reports
// R2: host writes zero to reserved bits
// R3: host never writes 09h to ffh
// R4: host ignores reserved read bits
// R5: operating flags clear on read if gone
// R6: wake status tracks pin, self-clears
// R7: discharge settings writable only when unlocked
// R8: charge settings writable only when unlocked
// R9: feature settings writable only when unlocked
// R10: force-sleep cleared at power up
// R11: wake edge of polarity clears sleep
// R12: host writing zero clears sleep
// R13: protection shutdown clears fet bits
// R14: fet bits drive fets, read logical
// R15: bit0 discharge fet, bit1 charge fet
// R16: charge delay divide by thirty-two
// R17: discharge delay divide by sixty-four
// R18: feature bit disables internal regulator
// R19: bit7 stops external temperature scan
// R20: bits disable thermal shutdown responses
// R21: analog select code chooses output
// R22: wake status follows polarity
// R23: eight-bit registers, eight-bit addresses
// assumes a serial bus engine on sys_clk_in presenting single-cycle write and
// read strobes with an 8-bit register address; analog blocks around it
`include "ppr_regs.svh"
`timescale 1ns/1ps
module ppr_reg_bank
  import ppr_pkg::*;
#(
  parameter int DELAY_W = 16 // width of delay counts passed to the timers
) (
  input  wire logic               sys_clk_in,
  input  wire logic               rst_n_in,
  // register access from the serial engine
  input  wire logic               wr_stb_in,        // one-cycle write strobe
  input  wire logic               rd_stb_in,        // one-cycle read strobe
  input  wire logic [7:0]         addr_in,          // register address
  input  wire logic [7:0]         wdata_in,         // write data
  output logic      [7:0]         rdata_out,        // read data, valid cycle after rd
  // pins and analog conditions (asynchronous)
  input  wire logic               wake_pin_in,      // wake pin comparator level
  input  wire logic [5:0]         cond_in,          // live status conditions
  input  wire logic               prot_trip_in,     // oc/short turned fets off
  // delays from the timer block, before division
  input  wire logic [DELAY_W-1:0] chg_delay_in,
  input  wire logic [DELAY_W-1:0] dsch_delay_in,
  // controls to the analog side
  output logic      [3:0]         analog_sel_out,   // analog output code
  output logic                    analog_off_out,   // low-power analog out
  output logic                    charge_switch_on_out,
  output logic                    discharge_switch_on_out,
  output logic                    load_monitor_enable_out,
  output logic                    force_sleep_out,
  output logic      [7:0]         dsch_set_out,
  output logic      [7:0]         chg_set_out,
  output logic                    temp_scan_off_out,
  output logic                    regulator_disable_out,
  output logic                    temp_supply_on_out,
  output logic                    ext_thermal_shutdown_off_out,
  output logic                    int_thermal_shutdown_off_out,
  output logic                    force_por_out,
  output logic      [DELAY_W-1:0] chg_delay_out,
  output logic      [DELAY_W-1:0] dsch_delay_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // synchronisers and local state
  // pins async: two flops,
  // two cycles of latency

  logic      wake_sync;   // synchronised wake pin
  logic [5:0] cond_sync;  // synchronised conditions
  logic      trip_sync;   // synchronised protection trip

  ppr_byte_t analog_q;    // analog select and user flags
  ppr_byte_t fet_q;       // fet_drive_control
  ppr_byte_t dsch_q;      // discharge settings
  ppr_byte_t chg_q;       // charge settings
  ppr_byte_t feat_q;      // feature settings
  ppr_byte_t unlock_q;    // write unlock and user flags

  logic      wake_prev_q; // previous wake status for edge detect
  logic      wake_stat;   // wake status after polarity
  // carrier to the keeper
  ppr_stat_if st ();

  // trip, wake, conditions
  ppr_sync2 #(.W(8)) u_sync (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .d_in       ({trip_sync_src(prot_trip_in), wake_pin_in, cond_in}),
    .q_out      ({trip_sync, wake_sync, cond_sync})
  );

  // identity for readability of the sync bundle
  function automatic logic trip_sync_src(input logic v);
    return v;
  endfunction

  // register write hit decode, used for every register
  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] target);
    return wr_stb_in && (a == target);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // status flags
  // sticky; a read hands live
  // conditions back in

  // already synchronised
  assign st.cond     = cond_sync;
  // R5: read strobe clears
  assign st.rd_clear = rd_stb_in && (addr_in == `PPR_ADDR_OP_STATUS);

  // flag keeper
  ppr_stat_keeper u_keeper (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .st         (st)
  );

  // R22: polarity applied
  // R6: follows pin live, no latch so it clears with the condition
  assign wake_stat = feat_q[`PPR_FEAT_POL_BIT] ? wake_sync : ~wake_sync;

  ////////////////////////////////////////////////////////////////////////////////
  // plain read/write registers
  // reserved bits masked
  // so they read zero

  // analog select and user flags; reserved bits masked
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // user flags reset too
      analog_q <= `PPR_RST_REG;
    end else if (wr_hit(addr_in, `PPR_ADDR_ANALOG_SEL)) begin
      // bits 5, 4 reserved
      analog_q <= wdata_in & `PPR_MASK_ANALOG_SEL;
    end
  end

  // write unlock register
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // all locked
      unlock_q <= `PPR_RST_REG;
    end else if (wr_hit(addr_in, `PPR_ADDR_WR_UNLOCK)) begin
      // bits 2..0 reserved
      unlock_q <= wdata_in & `PPR_MASK_WR_UNLOCK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // protected settings
  // locked writes drop;
  // unlock acts next edge

  // R7: discharge unlock gate
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // auto responses armed
      dsch_q <= `PPR_RST_REG;
    end else if (wr_hit(addr_in, `PPR_ADDR_DSCH_SET) && unlock_q[`PPR_UNL_DSCH_BIT]) begin
      // whole byte
      dsch_q <= wdata_in;
    end
  end

  // R8: charge unlock gate
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // no divide
      chg_q <= `PPR_RST_REG;
    end else if (wr_hit(addr_in, `PPR_ADDR_CHG_SET) && unlock_q[`PPR_UNL_CHG_BIT]) begin
      // whole byte
      chg_q <= wdata_in;
    end
  end

  // R9: feature unlock gate
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // polarity zero
      feat_q <= `PPR_RST_REG;
    end else if (wr_hit(addr_in, `PPR_ADDR_FEAT_SET) && unlock_q[`PPR_UNL_FEAT_BIT]) begin
      // whole byte
      feat_q <= wdata_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // fet_drive_control and sleep
  // wake clears sleep about
  // three edges after pin

  // wake edge history; reset to the idle level so no false edge at start
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // status idles high
      wake_prev_q <= 1'b1;
    end else begin
      wake_prev_q <= wake_stat;
    end
  end

  // fet bits and sleep; hardware clears win over host sets in the same cycle
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // R10: sleep clear at power up
      fet_q <= `PPR_RST_REG;
    end else begin
      // R14: host write drives fets
      // R12: zero write clears sleep
      if (wr_hit(addr_in, `PPR_ADDR_FET_CTRL)) begin
        // bits 5..2 reserved
        fet_q <= wdata_in & `PPR_MASK_FET_CTRL;
      end

      // R11: active wake edge
      // wake pin disabled blocks the wake-up path
      if (wake_stat && !wake_prev_q && !feat_q[`PPR_FEAT_WKDIS_BIT]) begin
        fet_q[`PPR_FET_SLEEP_BIT] <= 1'b0;
      end

      // R13: trip clears fets
      // only while automatic responses are on
      if (trip_sync && !(dsch_q[`PPR_DSCH_OCD_OFF_BIT] && dsch_q[`PPR_DSCH_SCD_OFF_BIT]
                         && chg_q[`PPR_CHG_OCC_OFF_BIT])) begin
        fet_q[`PPR_FET_DSCH_BIT] <= 1'b0;
        fet_q[`PPR_FET_CHG_BIT]  <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs to the analog side
  // flops: no glitches, one
  // cycle of latency

  // R1: written ones act
  // R15: bit0 discharge, bit1 charge
  // R18: regulator disable
  // R19: scan off
  // R20: thermal shutdown disables
  // R21: analog select decode
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // low-power analog
      analog_sel_out               <= 4'h0;
      analog_off_out               <= 1'b1;
      charge_switch_on_out         <= 1'b0;
      discharge_switch_on_out      <= 1'b0;
      load_monitor_enable_out      <= 1'b0;
      force_sleep_out              <= 1'b0;

      dsch_set_out                 <= `PPR_RST_REG;
      chg_set_out                  <= `PPR_RST_REG;
      temp_scan_off_out            <= 1'b0;
      regulator_disable_out        <= 1'b0;
      temp_supply_on_out           <= 1'b0;
      ext_thermal_shutdown_off_out <= 1'b0;
      int_thermal_shutdown_off_out <= 1'b0;
      force_por_out                <= 1'b0;
    end else begin
      // follow stored bits
      analog_sel_out               <= analog_q[3:0];
      analog_off_out               <= (analog_q[3:0] == 4'h0);
      charge_switch_on_out         <= fet_q[`PPR_FET_CHG_BIT];
      discharge_switch_on_out      <= fet_q[`PPR_FET_DSCH_BIT];
      load_monitor_enable_out      <= fet_q[`PPR_FET_LDMON_BIT];
      force_sleep_out              <= fet_q[`PPR_FET_SLEEP_BIT];

      // settings, whole
      dsch_set_out                 <= dsch_q;
      chg_set_out                  <= chg_q;

      // feature controls
      temp_scan_off_out            <= feat_q[`PPR_FEAT_SCANOFF_BIT];
      regulator_disable_out        <= feat_q[`PPR_FEAT_REGDIS_BIT];
      temp_supply_on_out           <= feat_q[`PPR_FEAT_T3ON_BIT];
      ext_thermal_shutdown_off_out <= feat_q[`PPR_FEAT_XTSD_BIT];
      int_thermal_shutdown_off_out <= feat_q[`PPR_FEAT_ITSD_BIT];
      force_por_out                <= feat_q[`PPR_FEAT_POR_BIT];
    end
  end

  // R16: charge divide 32
  // R17: discharge divide 64
  // shifting truncates; a short delay may reach zero, the timer must treat it as one
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // zero until updated
      chg_delay_out  <= '0;
      dsch_delay_out <= '0;
    end else begin
      // both divides here
      chg_delay_out  <= chg_q[`PPR_CHG_CDIV_BIT] ? (chg_delay_in >> `PPR_CHG_DIV_SHIFT)
                                                  : chg_delay_in;
      dsch_delay_out <= chg_q[`PPR_CHG_DDIV_BIT] ? (dsch_delay_in >> `PPR_DSCH_DIV_SHIFT)
                                                  : dsch_delay_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read path
  // 00 cfg 01 flags 02 none
  // 03 analog 04 fet
  // 05 dsch 06 chg 07 feat
  // 08 unlock; data holds

  // R23: eight-bit address decode
  // unused and reserved addresses read zero
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
    end else if (rd_stb_in) begin
      case (addr_in)
        `PPR_ADDR_CFG_STATUS: begin
          rdata_out <= 8'h00;
          // fixed high
          rdata_out[`PPR_CFG_SINGLE_BIT] <= 1'b1;
          rdata_out[`PPR_CFG_WAKE_BIT]   <= wake_stat;
        end
        // also clears flags
        `PPR_ADDR_OP_STATUS:  rdata_out <= {2'b00, st.flags};
        `PPR_ADDR_ANALOG_SEL: rdata_out <= analog_q;
        // R14: logical drive state
        `PPR_ADDR_FET_CTRL:   rdata_out <= fet_q;
        `PPR_ADDR_DSCH_SET:   rdata_out <= dsch_q;
        `PPR_ADDR_CHG_SET:    rdata_out <= chg_q;
        `PPR_ADDR_FEAT_SET:   rdata_out <= feat_q;
        `PPR_ADDR_WR_UNLOCK:  rdata_out <= unlock_q;
        // unused, reserved
        default:              rdata_out <= 8'h00;
      endcase
    end
  end

endmodule // ppr_reg_bank

// File: hdl/ppr_regs.svh
// register offsets, field positions, reset values for the pack protection register bank
// assumes an 8-bit register address carried by the serial bus engine outside
`ifndef PPR_REGS_SVH
`define PPR_REGS_SVH
`define PPR_ADDR_CFG_STATUS   8'h00
`define PPR_ADDR_OP_STATUS    8'h01
`define PPR_ADDR_UNUSED       8'h02
`define PPR_ADDR_ANALOG_SEL   8'h03
`define PPR_ADDR_FET_CTRL     8'h04
`define PPR_ADDR_DSCH_SET     8'h05
`define PPR_ADDR_CHG_SET      8'h06
`define PPR_ADDR_FEAT_SET     8'h07
`define PPR_ADDR_WR_UNLOCK    8'h08
// writable bit masks (reserved bits kept at zero)
`define PPR_MASK_ANALOG_SEL   8'hcf
`define PPR_MASK_FET_CTRL     8'hc3
`define PPR_MASK_WR_UNLOCK    8'hf8
// field positions
`define PPR_FET_DSCH_BIT      0
`define PPR_FET_CHG_BIT       1
`define PPR_FET_LDMON_BIT     6
`define PPR_FET_SLEEP_BIT     7
`define PPR_CHG_DDIV_BIT      2
`define PPR_CHG_CDIV_BIT      3
`define PPR_DSCH_OCD_OFF_BIT  7
`define PPR_DSCH_SCD_OFF_BIT  4
`define PPR_CHG_OCC_OFF_BIT   7
`define PPR_FEAT_POL_BIT      0
`define PPR_FEAT_WKDIS_BIT    1
`define PPR_FEAT_POR_BIT      2
`define PPR_FEAT_ITSD_BIT     3
`define PPR_FEAT_XTSD_BIT     4
`define PPR_FEAT_T3ON_BIT     5
`define PPR_FEAT_REGDIS_BIT   6
`define PPR_FEAT_SCANOFF_BIT  7
`define PPR_UNL_DSCH_BIT      5
`define PPR_UNL_CHG_BIT       6
`define PPR_UNL_FEAT_BIT      7
`define PPR_CFG_WAKE_BIT      4
`define PPR_CFG_SINGLE_BIT    5
// reset values
`define PPR_RST_REG           8'h00
// delay divide ratios (log2): charge by 32, discharge by 64
`define PPR_CHG_DIV_SHIFT     5
`define PPR_DSCH_DIV_SHIFT    6
`endif

// File: hdl/ppr_stat_if.sv
// carrier between the top and its status flag keeper
// assumes one clock domain
`timescale 1ns/1ps
interface ppr_stat_if;
  import ppr_pkg::*;
  ppr_flags_t cond;     // live conditions
  logic       rd_clear; // one-cycle read of the status register
  ppr_flags_t flags;    // latched flags
  modport keeper (input cond, input rd_clear, output flags);
  modport user   (output cond, output rd_clear, input flags);
endinterface

// File: hdl/ppr_stat_keeper.sv
// sticky operating status flags with clear-on-read
// assumes conditions already synchronised to sys_clk_in
`timescale 1ns/1ps
module ppr_stat_keeper
  import ppr_pkg::*;
(
  input  wire logic sys_clk_in,
  input  wire logic rst_n_in,
  ppr_stat_if.keeper st
);
  // R5: clear on read
  // a flag only drops on a read if its condition is gone; a live condition wins
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st.flags <= '0;
    end else if (st.rd_clear) begin
      st.flags <= st.cond;
    end else begin
      st.flags <= st.flags | st.cond;
    end
  end
endmodule // ppr_stat_keeper

// File: hdl/ppr_sync2.sv
// two-flop synchroniser for asynchronous pin levels
// assumes a single destination clock
`timescale 1ns/1ps
module ppr_sync2 #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_q; // first stage, read only by q_out
  // two flops before any logic reads the level
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= '0;
      q_out  <= '0;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule // ppr_sync2

// File: verification/ppr_host_model.sv
// host controller model issuing register accesses
// assumes strobes sampled on the rising edge
`include "ppr_regs.svh"
`timescale 1ns/1ps
module ppr_host_model (
  input  wire logic       sys_clk_in,
  output logic            wr_stb_out,
  output logic            rd_stb_out,
  output logic [7:0]      addr_out,
  output logic [7:0]      wdata_out,
  input  wire logic [7:0] rdata_in
);
  initial begin
    wr_stb_out = 1'b0;
    rd_stb_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end
  // one write; the released data bus shows the inverse, never the old value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] m;
    case (a)
      8'h02: m = 8'h00;
      8'h03: m = d & `PPR_MASK_ANALOG_SEL;
      8'h04: m = d & `PPR_MASK_FET_CTRL;
      8'h08: m = d & `PPR_MASK_WR_UNLOCK;
      default: m = d;
    endcase
    if (a > 8'h08) return;
    @(posedge sys_clk_in);
    wr_stb_out <= 1'b1;
    addr_out <= a;
    wdata_out <= m;
    @(posedge sys_clk_in);
    wr_stb_out <= 1'b0;
    wdata_out <= ~m;
  endtask
  // one read; data taken a cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    rd_stb_out <= 1'b1;
    addr_out <= a;
    @(posedge sys_clk_in);
    rd_stb_out <= 1'b0;
    addr_out <= ~a;
    #1;
    d = rdata_in;
  endtask
endmodule // ppr_host_model

// File: verification/ppr_reg_bank_sva.sv
// port assertions for the register bank
// assumes bind onto ppr_reg_bank, one clock
`timescale 1ns/1ps
module ppr_reg_bank_sva #(
  parameter int DELAY_W = 16
) (
  input wire logic               sys_clk_in,
  input wire logic               rst_n_in,
  input wire logic               wr_stb_in,
  input wire logic               rd_stb_in,
  input wire logic [7:0]         addr_in,
  input wire logic [7:0]         wdata_in,
  input wire logic [7:0]         rdata_out,
  input wire logic [5:0]         cond_in,
  input wire logic               prot_trip_in,
  input wire logic [DELAY_W-1:0] chg_delay_in,
  input wire logic [7:0]         chg_set_out,
  input wire logic [7:0]         dsch_set_out,
  input wire logic               analog_off_out,
  input wire logic [3:0]         analog_sel_out,
  input wire logic               charge_switch_on_out,
  input wire logic               discharge_switch_on_out,
  input wire logic               force_sleep_out,
  input wire logic [DELAY_W-1:0] chg_delay_out
);
  //////////////////////////////////////////////////////////////////////
  logic [2:0]         unl_q;  // mirror of the unlock bits
  logic [2:0]         quiet_q; // cycles with no live condition
  logic [1:0]         stab_q; // cycles with steady delay inputs
  logic [DELAY_W-1:0] din_q;  // last delay input
  logic [7:0]         cset_q; // last charge settings
  logic               auto_on; // automatic shutdown armed
  assign auto_on = !(dsch_set_out[7] && dsch_set_out[4] && chg_set_out[7]);
  // helper state; the sync path makes a settle count necessary
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      unl_q <= 3'h0;
      quiet_q <= 3'h0;
      stab_q <= 2'h0;
      din_q <= '0;
      cset_q <= 8'h00;
    end else begin
      din_q <= chg_delay_in;
      cset_q <= chg_set_out;
      if (wr_stb_in && addr_in == 8'h08) unl_q <= wdata_in[7:5];
      if (cond_in != 6'h00) quiet_q <= 3'h0;
      else if (quiet_q != 3'h4) quiet_q <= quiet_q + 3'h1;
      if (din_q != chg_delay_in || cset_q != chg_set_out) stab_q <= 2'h0;
      else if (stab_q != 2'h3) stab_q <= stab_q + 2'h1;
    end
  end
  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_rd01;
    rd_stb_in && addr_in == 8'h01 && quiet_q == 3'h4;
  endsequence
  property p_aoff; analog_off_out == (analog_sel_out == 4'h0); endproperty
  a_aoff: assert property (p_aoff) else $error("analog off flag wrong");
  property p_fet;
    wr_stb_in && addr_in == 8'h04 && !prot_trip_in && !$past(prot_trip_in) &&
      !$past(prot_trip_in, 2) && !$past(prot_trip_in, 3) |-> ##2
      {6'h00, charge_switch_on_out, discharge_switch_on_out} == ($past(wdata_in, 2) & 8'h03);
  endproperty
  a_fet: assert property (p_fet) else $error("fet drive wrong");
  property p_clock;
    wr_stb_in && addr_in == 8'h06 && !unl_q[1] |-> ##2 chg_set_out == $past(chg_set_out, 2);
  endproperty
  a_clock: assert property (p_clock) else $error("locked write landed");
  property p_dopen;
    wr_stb_in && addr_in == 8'h05 && unl_q[0] |-> ##2 dsch_set_out == $past(wdata_in, 2);
  endproperty
  a_dopen: assert property (p_dopen) else $error("unlocked write lost");
  property p_cdiv;
    stab_q == 2'h3 |-> chg_delay_out == (chg_set_out[3] ? chg_delay_in >> 5 : chg_delay_in);
  endproperty
  a_cdiv: assert property (p_cdiv) else $error("charge delay wrong");
  property p_clr; s_rd01 ##2 s_rd01 |-> ##1 rdata_out == 8'h00; endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  property p_trip;
    (prot_trip_in && auto_on) [*3] |-> ##3 !charge_switch_on_out && !discharge_switch_on_out;
  endproperty
  a_trip: assert property (p_trip) else $error("fet left on");
  property p_wake; wr_stb_in && addr_in == 8'h04 && !wdata_in[7] |-> ##2 !force_sleep_out;
  endproperty
  a_wake: assert property (p_wake) else $error("sleep not cleared");
  property p_rsvd; rd_stb_in && (addr_in == 8'h02 || addr_in > 8'h08) |-> ##1 rdata_out == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved read not zero");
  c_trip: cover property ((prot_trip_in && auto_on) [*3]);
  c_clr: cover property (s_rd01 ##2 s_rd01);
  c_unl: cover property (wr_stb_in && addr_in == 8'h08 && wdata_in[7:5] == 3'h7);
endmodule // ppr_reg_bank_sva

bind ppr_reg_bank ppr_reg_bank_sva #(.DELAY_W(DELAY_W)) i_ppr_reg_bank_sva (
  .sys_clk_in, .rst_n_in, .wr_stb_in, .rd_stb_in, .addr_in, .wdata_in, .rdata_out,
  .cond_in, .prot_trip_in, .chg_delay_in, .chg_set_out, .dsch_set_out, .analog_off_out,
  .analog_sel_out, .charge_switch_on_out, .discharge_switch_on_out, .force_sleep_out,
  .chg_delay_out
);

// File: verification/tb_top.sv
// self-checking bench for the register bank
// assumes the host model drives the register strobes
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0;  // 100 MHz
  logic        rst_n;       // async reset
  logic        wake;        // wake pin level
  logic [5:0]  cond;        // live conditions
  logic        trip;        // protection trip
  logic [15:0] dly, cdly, ddly; // delays in and out
  logic        wr, rd, aoff, chg_on, dis_on, ldmon, sleep;
  logic        scan_off, reg_dis, t3on, xtsd, itsd, por;
  logic [7:0]  addr, wd, rdata, dset, cset, d;
  logic [3:0]  sel;
  int          errors = 0;
  int          check_count = 0;
  always #5 clk = ~clk;
  ppr_reg_bank i_ppr_reg_bank (.sys_clk_in(clk), .rst_n_in(rst_n), .wr_stb_in(wr),
    .rd_stb_in(rd), .addr_in(addr), .wdata_in(wd), .rdata_out(rdata), .wake_pin_in(wake),
    .cond_in(cond), .prot_trip_in(trip), .chg_delay_in(dly), .dsch_delay_in(dly),
    .analog_sel_out(sel), .analog_off_out(aoff), .charge_switch_on_out(chg_on),
    .discharge_switch_on_out(dis_on), .load_monitor_enable_out(ldmon),
    .force_sleep_out(sleep), .dsch_set_out(dset), .chg_set_out(cset),
    .temp_scan_off_out(scan_off), .regulator_disable_out(reg_dis),
    .temp_supply_on_out(t3on), .ext_thermal_shutdown_off_out(xtsd),
    .int_thermal_shutdown_off_out(itsd), .force_por_out(por), .chg_delay_out(cdly),
    .dsch_delay_out(ddly));
  ppr_host_model i_ppr_host_model (.sys_clk_in(clk), .wr_stb_out(wr), .rd_stb_out(rd),
    .addr_out(addr), .wdata_out(wd), .rdata_in(rdata));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // outputs trail a write by two edges
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk({sleep, aoff, por}, 3'b010);
    i_ppr_host_model.rd(8'h00, d);
    chk(d & 8'h30, 8'h30);
    i_ppr_host_model.rd(8'h02, d);
    chk(d, 8'h00);
    i_ppr_host_model.rd(8'h09, d);
    chk(d, 8'h00);
  endtask
  task automatic t_locks();
    i_ppr_host_model.wr(8'h05, 8'h5a);
    i_ppr_host_model.wr(8'h06, 8'h0c);
    i_ppr_host_model.wr(8'h07, 8'hf8);
    settle();
    chk({dset, cset}, 16'h0000);
    chk(scan_off, 1'b0);
    i_ppr_host_model.wr(8'h08, 8'hff);
    i_ppr_host_model.rd(8'h08, d);
    chk(d, 8'hf8);
    i_ppr_host_model.wr(8'h05, 8'h5a);
    i_ppr_host_model.wr(8'h06, 8'h0c);
    i_ppr_host_model.wr(8'h07, 8'hf8);
    settle();
    chk({dset, cset}, 16'h5a0c);
    chk({scan_off, reg_dis, t3on, xtsd, itsd}, 5'h1f);
    chk(cdly, 16'h07ff);
    chk(ddly, 16'h03ff);
    i_ppr_host_model.wr(8'h07, 8'h00);
    i_ppr_host_model.wr(8'h06, 8'h00);
    settle();
    chk(cdly, 16'hffff);
    chk({scan_off, reg_dis, itsd}, 3'h0);
  endtask
  task automatic t_fet();
    i_ppr_host_model.wr(8'h04, 8'h43);
    settle();
    chk({ldmon, chg_on, dis_on}, 3'b111);
    i_ppr_host_model.wr(8'h04, 8'h01);
    i_ppr_host_model.rd(8'h04, d);
    chk({chg_on, dis_on, d}, {2'b01, 8'h01});
    @(posedge clk) trip <= 1'b1;
    repeat (8) @(posedge clk);
    trip <= 1'b0;
    i_ppr_host_model.rd(8'h04, d);
    chk({chg_on, dis_on, d & 8'h03}, 10'h000);
  endtask
  task automatic t_sleep();
    i_ppr_host_model.wr(8'h04, 8'h80);
    settle();
    chk(sleep, 1'b1);
    i_ppr_host_model.wr(8'h04, 8'h00);
    settle();
    chk(sleep, 1'b0);
    i_ppr_host_model.wr(8'h04, 8'h80);
    @(posedge clk) wake <= 1'b1;
    repeat (2) @(posedge clk);
    i_ppr_host_model.rd(8'h00, d);
    chk({sleep, d & 8'h30}, 9'h120);
    @(posedge clk) wake <= 1'b0;
    repeat (6) @(posedge clk);
    chk(sleep, 1'b0);
    i_ppr_host_model.wr(8'h07, 8'h01);
    i_ppr_host_model.wr(8'h04, 8'h80);
    settle();
    chk(sleep, 1'b1);
    @(posedge clk) wake <= 1'b1;
    repeat (6) @(posedge clk);
    chk(sleep, 1'b0);
    i_ppr_host_model.wr(8'h07, 8'h02);
    i_ppr_host_model.wr(8'h04, 8'h80);
    @(posedge clk) wake <= 1'b0;
    repeat (6) @(posedge clk);
    chk(sleep, 1'b1);
    i_ppr_host_model.wr(8'h07, 8'h00);
  endtask
  task automatic t_status();
    @(posedge clk) cond <= 6'h3f;
    @(posedge clk) cond <= 6'h00;
    repeat (6) @(posedge clk);
    i_ppr_host_model.rd(8'h01, d);
    chk(d, 8'h3f);
    i_ppr_host_model.rd(8'h01, d);
    chk(d, 8'h00);
    @(posedge clk) cond <= 6'h04;
    repeat (6) @(posedge clk);
    i_ppr_host_model.rd(8'h01, d);
    i_ppr_host_model.rd(8'h01, d);
    chk(d, 8'h04);
    @(posedge clk) cond <= 6'h00;
    repeat (6) @(posedge clk);
    i_ppr_host_model.rd(8'h01, d);
    i_ppr_host_model.rd(8'h01, d);
    chk(d, 8'h00);
  endtask
  task automatic t_analog();
    i_ppr_host_model.wr(8'h03, 8'hff);
    i_ppr_host_model.rd(8'h03, d);
    chk({aoff, sel, d}, {5'h0f, 8'hcf});
    i_ppr_host_model.wr(8'h03, 8'h01);
    settle();
    chk({aoff, sel}, 5'h01);
    i_ppr_host_model.wr(8'h03, 8'h00);
    settle();
    chk({aoff, sel}, 5'h10);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    wake = 1'b0;
    cond = 6'h00;
    trip = 1'b0;
    dly = 16'hffff;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_locks();
    t_fet();
    t_sleep();
    t_status();
    t_analog();
    end_of_test();
  end
  // hang guard, well past the fewer than two hundred cycles needed
  initial begin
    #200000;
    errors++;
    end_of_test();
  end
endmodule // tb_top
